// *** common/dpc_pkg.sv ***
// Function
// R1: Bypass bits act only when component code zero
// R2: Resistor R3 code, 4 bits, resets 0x8
// R3: Charge-pump current code, 6 bits, resets 0x20
// R4: VCO divider 01/10/11 gives 4/8/16
// R5: Software keeps VCO within 6 to 12 GHz
// R6: Predivider 000/001/010 gives 1/2/4, resets 001
// R7: Software keeps PLL reference 35 to 80 MHz
// R8: Feedback count never below six
// R9: Reserved bits read zero, ignore writes
`default_nettype none
package dpc_pkg;
  // ==========================================================
  // Register map
  localparam int          ADDR_W        = 10;
  localparam logic [9:0]  LF3_ADDR      = 10'h089;
  localparam logic [9:0]  CP_ADDR       = 10'h08A;
  localparam logic [9:0]  VCO_ADDR      = 10'h08B;
  localparam logic [9:0]  REF_ADDR      = 10'h08C;
  // ==========================================================
  // Field positions
  localparam int          SKIP_RES3_BIT = 7;
  localparam int          SKIP_RES1_BIT = 6;
  localparam int          SKIP_CAP2_BIT = 5;
  localparam int          SKIP_CAP1_BIT = 4;
  localparam int          RES3_MSB      = 3;
  localparam int          CP_MSB        = 5;
  localparam int          VCO_MSB       = 1;
  localparam int          REF_MSB       = 2;
  // ==========================================================
  // Reset values
  localparam logic [7:0]  LF3_RESET     = 8'h08;
  localparam logic [5:0]  CP_RESET      = 6'h20;
  localparam logic [1:0]  VCO_RESET     = 2'h2;
  localparam logic [2:0]  REF_RESET     = 3'h1;
  // ==========================================================
  // Divider encodings and feedback count floor
  localparam logic [1:0]  VCO_SEL_4     = 2'h1;
  localparam logic [1:0]  VCO_SEL_8     = 2'h2;
  localparam logic [1:0]  VCO_SEL_16    = 2'h3;
  localparam logic [2:0]  REF_SEL_1     = 3'h0;
  localparam logic [2:0]  REF_SEL_2     = 3'h1;
  localparam logic [2:0]  REF_SEL_4     = 3'h2;
  localparam logic [7:0]  FB_COUNT_MIN  = 8'h06;
endpackage
`default_nettype wire

// *** core/dpc_regs.sv ***
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module dpc_regs (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic [dpc_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]                 reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [7:0]                 reg_rdata,
  input  wire logic [3:0]                 res1_value_code,
  input  wire logic [3:0]                 cap2_value_code,
  input  wire logic [3:0]                 cap1_value_code,
  input  wire logic [7:0]                 fb_count_req,
  output logic      [3:0]                 loop_res3_code,
  output logic                            skip_loop_res3,
  output logic                            skip_loop_res1,
  output logic                            skip_loop_cap2,
  output logic                            skip_loop_cap1,
  output logic      [5:0]                 pump_current_code,
  output logic      [1:0]                 vco_divide_select,
  output logic      [4:0]                 vco_div_ratio,
  output logic      [2:0]                 ref_div_ratio,
  output logic      [7:0]                 fb_count_used
);
  import dpc_pkg::*;

  // ==========================================================
  // Storage: only implemented bits exist, reserved bits have no flops
  logic [7:0] lf3_ff;
  logic [5:0] cp_ff;
  logic [1:0] vco_ff;
  logic [2:0] ref_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [3:0] skip_ff;
  logic [4:0] vco_ratio_ff;
  logic [2:0] ref_ratio_ff;
  logic [7:0] fb_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lf3_ff <= LF3_RESET;
    end else if (reg_wr && reg_addr == LF3_ADDR) begin
      lf3_ff <= reg_wdata;  // [R2]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cp_ff <= CP_RESET;
    end else if (reg_wr && reg_addr == CP_ADDR) begin
      cp_ff <= reg_wdata[CP_MSB:0];  // [R3] [R9]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vco_ff <= VCO_RESET;
    end else if (reg_wr && reg_addr == VCO_ADDR) begin
      vco_ff <= reg_wdata[VCO_MSB:0];  // [R4] [R9]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ref_ff <= REF_RESET;
    end else if (reg_wr && reg_addr == REF_ADDR) begin
      ref_ff <= reg_wdata[REF_MSB:0];  // [R6] [R9]
    end
  end

  // ==========================================================
  // Read path, unmapped addresses read zero
  always_comb begin
    nxt_rdata = 8'h00;
    unique case (reg_addr)
      LF3_ADDR: nxt_rdata = lf3_ff;
      CP_ADDR:  nxt_rdata = {2'h0, cp_ff};  // [R9]
      VCO_ADDR: nxt_rdata = {6'h00, vco_ff};  // [R9]
      REF_ADDR: nxt_rdata = {5'h00, ref_ff};  // [R9]
      default:  nxt_rdata = 8'h00;
    endcase
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  // ==========================================================
  // Bypass gating: a set bit shorts its part only at code zero,
  // otherwise the analog side would see a bypass fighting a code
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      skip_ff <= 4'h0;
    end else begin
      skip_ff[3] <= lf3_ff[SKIP_RES3_BIT] && lf3_ff[RES3_MSB:0] == 4'h0;  // [R1]
      skip_ff[2] <= lf3_ff[SKIP_RES1_BIT] && res1_value_code == 4'h0;  // [R1]
      skip_ff[1] <= lf3_ff[SKIP_CAP2_BIT] && cap2_value_code == 4'h0;  // [R1]
      skip_ff[0] <= lf3_ff[SKIP_CAP1_BIT] && cap1_value_code == 4'h0;  // [R1]
    end
  end

  // ==========================================================
  // Divider decode; illegal codes give ratio zero as a flag
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vco_ratio_ff <= 5'h08;
    end else begin
      unique case (vco_ff)
        VCO_SEL_4:  vco_ratio_ff <= 5'h04;  // [R4]
        VCO_SEL_8:  vco_ratio_ff <= 5'h08;  // [R4]
        VCO_SEL_16: vco_ratio_ff <= 5'h10;  // [R4]
        default:    vco_ratio_ff <= 5'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ref_ratio_ff <= 3'h2;
    end else begin
      unique case (ref_ff)
        REF_SEL_1: ref_ratio_ff <= 3'h1;  // [R6]
        REF_SEL_2: ref_ratio_ff <= 3'h2;  // [R6]
        REF_SEL_4: ref_ratio_ff <= 3'h4;  // [R6]
        default:   ref_ratio_ff <= 3'h0;
      endcase
    end
  end

  // Clamp keeps the multiplier legal even if software writes less
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fb_ff <= FB_COUNT_MIN;
    end else if (fb_count_req < FB_COUNT_MIN) begin
      fb_ff <= FB_COUNT_MIN;  // [R8]
    end else begin
      fb_ff <= fb_count_req;  // [R8]
    end
  end

  assign reg_rdata         = rdata_ff;
  assign loop_res3_code    = lf3_ff[RES3_MSB:0];
  assign skip_loop_res3    = skip_ff[3];
  assign skip_loop_res1    = skip_ff[2];
  assign skip_loop_cap2    = skip_ff[1];
  assign skip_loop_cap1    = skip_ff[0];
  assign pump_current_code = cp_ff;
  assign vco_divide_select = vco_ff;
  assign vco_div_ratio     = vco_ratio_ff;
  assign ref_div_ratio     = ref_ratio_ff;
  assign fb_count_used     = fb_ff;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Bus steps, one strobe cycle each
  sequence wr_lf3_s;
    reg_wr && reg_addr == LF3_ADDR;
  endsequence
  sequence wr_cp_s;
    reg_wr && reg_addr == CP_ADDR;
  endsequence
  sequence wr_vco_s;
    reg_wr && reg_addr == VCO_ADDR;
  endsequence
  sequence wr_ref_s;
    reg_wr && reg_addr == REF_ADDR;
  endsequence
  sequence rd_lf3_s;
    reg_rd && reg_addr == LF3_ADDR;
  endsequence
  sequence rd_cp_s;
    reg_rd && reg_addr == CP_ADDR;
  endsequence
  sequence rd_vco_s;
    reg_rd && reg_addr == VCO_ADDR;
  endsequence
  sequence rd_ref_s;
    reg_rd && reg_addr == REF_ADDR;
  endsequence
  sequence rd_unmapped_s;
    reg_rd && reg_addr != LF3_ADDR && reg_addr != CP_ADDR
      && reg_addr != VCO_ADDR && reg_addr != REF_ADDR;
  endsequence

  // ==========================================================
  // Reset leaves every field and every decode at its start value
  reset_values_a: assert property (!$past(rst_n) |-> lf3_ff == LF3_RESET //[R2]
      && cp_ff == CP_RESET && vco_ff == VCO_RESET && ref_ff == REF_RESET)
    else $error("register reset values wrong");
  reset_derived_a: assert property (!$past(rst_n) |-> vco_div_ratio == 5'h08 //[R4]
      && ref_div_ratio == 3'h2 && fb_count_used == FB_COUNT_MIN && reg_rdata == 8'h00)
    else $error("derived reset values wrong");

  // ==========================================================
  // Writes land at the strobe edge; reserved bits are dropped
  lf3_write_a: assert property (wr_lf3_s |=> lf3_ff == $past(reg_wdata)) //[R1]
    else $error("loop filter byte not written");
  res3_write_a: assert property (wr_lf3_s //[R2]
      |=> {4'h0, loop_res3_code} == ($past(reg_wdata) & 8'h0F))
    else $error("res3 code not written");
  pump_store_a: assert property (wr_cp_s //[R3]
      |=> {2'h0, pump_current_code} == ($past(reg_wdata) & 8'h3F))
    else $error("pump code not written");
  vco_store_a: assert property (wr_vco_s //[R4]
      |=> {6'h00, vco_divide_select} == ($past(reg_wdata) & 8'h03))
    else $error("vco divider select not written");
  ref_store_a: assert property (wr_ref_s //[R6]
      |=> {5'h00, ref_ff} == ($past(reg_wdata) & 8'h07))
    else $error("reference divider select not written");
  pump_hold_a: assert property (!reg_wr |=> $stable(pump_current_code)) //[R3]
    else $error("pump code changed without a write");
  lf3_hold_a: assert property (!reg_wr |=> $stable(lf3_ff)) //[R2]
    else $error("loop filter byte changed without a write");
  vco_hold_a: assert property (!reg_wr |=> $stable(vco_divide_select)) //[R4]
    else $error("vco divider select changed without a write");
  ref_hold_a: assert property (!reg_wr |=> $stable(ref_ff)) //[R6]
    else $error("reference divider select changed without a write");
  stray_write_a: assert property (reg_wr && reg_addr > REF_ADDR //[R9]
      |=> $stable(lf3_ff) && $stable(cp_ff) && $stable(vco_ff) && $stable(ref_ff))
    else $error("unmapped write changed a register");

  // ==========================================================
  // Reads: data only in the cycle after the strobe
  lf3_read_a: assert property (rd_lf3_s |=> reg_rdata == $past(lf3_ff)) //[R2]
    else $error("loop filter byte readback wrong");
  pump_write_a: assert property (wr_cp_s ##1 rd_cp_s //[R3]
      |=> reg_rdata == ($past(reg_wdata, 2) & 8'h3F))
    else $error("pump code readback wrong");
  reserved_zero_a: assert property (rd_cp_s |=> reg_rdata[7:6] == 2'h0) //[R9]
    else $error("reserved bits read nonzero");
  vco_reserved_a: assert property (rd_vco_s |=> reg_rdata[7:2] == 6'h00) //[R9]
    else $error("vco register reserved bits read nonzero");
  ref_reserved_a: assert property (rd_ref_s |=> reg_rdata[7:3] == 5'h00) //[R9]
    else $error("reference register reserved bits read nonzero");
  vco_read_a: assert property (rd_vco_s |=> reg_rdata[1:0] == $past(vco_divide_select)) //[R4]
    else $error("vco divider select readback wrong");
  ref_read_a: assert property (rd_ref_s |=> reg_rdata[2:0] == $past(ref_ff)) //[R6]
    else $error("reference divider select readback wrong");
  unmapped_read_a: assert property (rd_unmapped_s |=> reg_rdata == 8'h00) //[R9]
    else $error("unmapped address read nonzero");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00) //[R9]
    else $error("read data stands without a read");

  // ==========================================================
  // Bypass gating, one cycle behind the bit and the code
  bypass_gate_a: assert property (skip_loop_res3 //[R1]
      |-> ($past(lf3_ff) & 8'h8F) == 8'h80)
    else $error("res3 bypass with nonzero code");
  res3_skip_a: assert property (lf3_ff[SKIP_RES3_BIT] && lf3_ff[RES3_MSB:0] == 4'h0 //[R1]
      |=> skip_loop_res3)
    else $error("res3 bypass not applied");
  res1_gate_a: assert property (res1_value_code != 4'h0 |=> !skip_loop_res1) //[R1]
    else $error("res1 bypass with nonzero code");
  res1_skip_a: assert property (lf3_ff[SKIP_RES1_BIT] && res1_value_code == 4'h0 //[R1]
      |=> skip_loop_res1)
    else $error("res1 bypass not applied");
  cap2_gate_a: assert property (cap2_value_code != 4'h0 |=> !skip_loop_cap2) //[R1]
    else $error("cap2 bypass with nonzero code");
  cap2_skip_a: assert property (lf3_ff[SKIP_CAP2_BIT] && cap2_value_code == 4'h0 //[R1]
      |=> skip_loop_cap2)
    else $error("cap2 bypass not applied");
  cap1_gate_a: assert property (cap1_value_code != 4'h0 |=> !skip_loop_cap1) //[R1]
    else $error("cap1 bypass with nonzero code");
  cap1_skip_a: assert property (lf3_ff[SKIP_CAP1_BIT] && cap1_value_code == 4'h0 //[R1]
      |=> skip_loop_cap1)
    else $error("cap1 bypass not applied");

  // ==========================================================
  // Divider decode, one cycle behind the select
  vco_ratio_a: assert property (vco_divide_select == VCO_SEL_16 && $past(vco_ff) == vco_ff //[R4]
      |=> vco_div_ratio == 5'h10)
    else $error("vco divide by 16 not decoded");
  vco_div4_a: assert property (vco_ff == VCO_SEL_4 |=> vco_div_ratio == 5'h04) //[R4]
    else $error("vco divide by 4 not decoded");
  vco_div8_a: assert property (vco_ff == VCO_SEL_8 |=> vco_div_ratio == 5'h08) //[R4]
    else $error("vco divide by 8 not decoded");
  vco_bad_a: assert property (vco_ff == 2'h0 |=> vco_div_ratio == 5'h00) //[R4]
    else $error("illegal vco select not flagged");
  ref_div1_a: assert property (ref_ff == REF_SEL_1 |=> ref_div_ratio == 3'h1) //[R6]
    else $error("reference divide by 1 not decoded");
  ref_div2_a: assert property (ref_ff == REF_SEL_2 |=> ref_div_ratio == 3'h2) //[R6]
    else $error("reference divide by 2 not decoded");
  ref_ratio_a: assert property (ref_ff == REF_SEL_4 |=> ref_div_ratio == 3'h4) //[R6]
    else $error("reference divide by 4 not decoded");
  ref_bad_a: assert property (ref_ff > REF_SEL_4 |=> ref_div_ratio == 3'h0) //[R6]
    else $error("illegal reference select not flagged");

  // ==========================================================
  // Feedback count floor
  fb_minimum_a: assert property (fb_count_req < FB_COUNT_MIN //[R8]
      |=> fb_count_used == FB_COUNT_MIN)
    else $error("feedback count below minimum");
  fb_pass_a: assert property (fb_count_req >= FB_COUNT_MIN //[R8]
      |=> fb_count_used == $past(fb_count_req))
    else $error("legal feedback count altered");
endmodule
`default_nettype wire

// *** testbench/tb_dac_pll_config_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_dac_pll_config_regs;
  import dpc_pkg::*;
  logic       clk = 1'h0;
  logic       rst_n = 1'h0;
  logic [9:0] reg_addr = 10'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'h0;
  logic       reg_rd = 1'h0;
  logic [7:0] reg_rdata;
  logic [3:0] res1_c = 4'h0, cap2_c = 4'h0, cap1_c = 4'h0, res3_code;
  logic [7:0] fb_req = 8'h00, fb_used, v;
  logic       sk_r3, sk_r1, sk_c2, sk_c1;
  logic [5:0] pump;
  logic [1:0] vco_sel;
  logic [4:0] vco_ratio;
  logic [2:0] ref_ratio;
  logic [7:0] exp_q[$];
  logic       rd_d = 1'h0;
  int         fail_count = 0;
  int         n_checks = 0;
  int         seed = 21;

  dpc_regs dpc_regs_inst (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .res1_value_code(res1_c),
    .cap2_value_code(cap2_c), .cap1_value_code(cap1_c), .fb_count_req(fb_req),
    .loop_res3_code(res3_code), .skip_loop_res3(sk_r3), .skip_loop_res1(sk_r1),
    .skip_loop_cap2(sk_c2), .skip_loop_cap1(sk_c1), .pump_current_code(pump),
    .vco_divide_select(vco_sel), .vco_div_ratio(vco_ratio), .ref_div_ratio(ref_ratio),
    .fb_count_used(fb_used));

  initial begin
    forever #4 clk = ~clk;
  end

  // ==========================================================
  // Bus tasks
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'h1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'h0;
  endtask

  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd   <= 1'h1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge clk);
    reg_rd   <= 1'h0;
  endtask

  // Derived outputs lag the register by one cycle
  task automatic settle;
    @(posedge clk);
    #1;
  endtask

  task automatic results;
    if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ==========================================================
  // Read data monitor
  always @(posedge clk) begin : mon
    logic [7:0] e;
    if (rd_d) begin
      e = exp_q.pop_front();
      `CHK("reg_rdata", e, reg_rdata)
    end else if (rst_n) begin
      `CHK("idle reg_rdata", 8'h00, reg_rdata)
    end
    rd_d <= reg_rd;
  end

  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    results;
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    settle;
    `CHK("loop_res3_code", 4'h8, res3_code)
    `CHK("pump_current_code", 6'h20, pump)
    `CHK("vco_div_ratio", 5'h08, vco_ratio)
    `CHK("ref_div_ratio", 3'h2, ref_ratio)
    `CHK("skip bits", 4'h0, ({sk_r3, sk_r1, sk_c2, sk_c1}))
    rd(LF3_ADDR, 8'h08);
    rd(CP_ADDR, 8'h20);
    rd(VCO_ADDR, 8'h02);
    rd(REF_ADDR, 8'h01);
    // Reserved bits and an unmapped address swallow writes
    wr(CP_ADDR, 8'hFF);
    wr(VCO_ADDR, 8'hFF);
    wr(REF_ADDR, 8'hFF);
    wr(10'h08D, 8'hFF);
    rd(CP_ADDR, 8'h3F);
    rd(VCO_ADDR, 8'h03);
    rd(REF_ADDR, 8'h07);
    rd(10'h08D, 8'h00);
    // Write then read of the pump code with no idle cycle between
    @(posedge clk);
    reg_wr    <= 1'h1;
    reg_addr  <= CP_ADDR;
    reg_wdata <= 8'hD5;
    @(posedge clk);
    reg_wr    <= 1'h0;
    reg_rd    <= 1'h1;
    exp_q.push_back(8'h15);
    @(posedge clk);
    reg_rd    <= 1'h0;
    for (int i = 0; i < 4; i++) begin
      wr(VCO_ADDR, 8'(i));
      settle;
      `CHK("vco_div_ratio", ((i == 0) ? 5'h00 : 5'(2 << i)), vco_ratio)
      `CHK("vco_divide_select", 2'(i), vco_sel)
    end
    for (int i = 0; i < 8; i++) begin
      wr(REF_ADDR, 8'(i));
      settle;
      `CHK("ref_div_ratio", ((i < 3) ? 3'(1 << i) : 3'h0), ref_ratio)
    end
    // A legal setup: a fast input divided by 4, VCO divided by 16
    wr(REF_ADDR, 8'(REF_SEL_4));
    wr(VCO_ADDR, 8'(VCO_SEL_16));
    settle;
    `CHK("ref_div_ratio", 3'h4, ref_ratio)
    `CHK("vco_div_ratio", 5'h10, vco_ratio)
    // Random bypass, pump and feedback settings; early passes zero the code
    for (int i = 0; i < 24; i++) begin
      v = 8'($random(seed));
      if (i < 8) v[3:0] = 4'h0;
      @(posedge clk);
      res1_c <= 4'($random(seed)) & {4{v[0]}};
      cap2_c <= 4'($random(seed)) & {4{v[1]}};
      cap1_c <= 4'($random(seed)) & {4{v[2]}};
      fb_req <= 8'($random(seed)) & 8'h0F;
      wr(LF3_ADDR, v);
      wr(CP_ADDR, ~v);
      settle;
      `CHK("skip bits", ({v[7] & (v[3:0] == 4'h0), v[6] & (res1_c == 4'h0),
        v[5] & (cap2_c == 4'h0), v[4] & (cap1_c == 4'h0)}), ({sk_r3, sk_r1, sk_c2, sk_c1}))
      `CHK("loop_res3_code", v[3:0], res3_code)
      `CHK("pump_current_code", ~v[5:0], pump)
      `CHK("fb_count_used", ((fb_req < 8'h06) ? 8'h06 : fb_req), fb_used)
      rd(LF3_ADDR, v);
    end
    // Second reset in mid-run
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    settle;
    `CHK("vco_div_ratio", 5'h08, vco_ratio)
    `CHK("ref_div_ratio", 3'h2, ref_ratio)
    `CHK("loop_res3_code", 4'h8, res3_code)
    `CHK("skip bits", 4'h0, ({sk_r3, sk_r1, sk_c2, sk_c1}))
    rd(CP_ADDR, 8'h20);
    rd(LF3_ADDR, 8'h08);
    repeat (3) @(posedge clk);
    results;
  end
endmodule
`default_nettype wire
